/* logic/clp_cfg.svh */
// constants of the cold load pick-up detector
//
// Behaviour
// - block input sampled once per program cycle
// - unblocked pick-up raises pickup_active, starts timing
// - blocked pick-up raises blocked, nothing more
// - block during pick-up releases like normal release
// - low current must last low_dwell_time
// - high current time limited by high_current_limit_time
// - pick-up held at least minimum_hold_time before a release on return to normal current
// - zero dwell time picks up at once
// - low ending early gives no pick-up
// - high current starts the high timer
// - return between thresholds ends start-up
// - overcurrent releases pick-up immediately
// - high timer expiry releases pick-up
// - no inrush: hold minimum time, release
// - inrush during hold runs high timer
// - selectable ON/OFF events for six conditions
// - clearable counters of activations and blocks
// - rolling twelve-record time-stamped log
// - five-state condition status
// - logical node behaviour, visible when enabled
// - low means all phases below low threshold
// - high means all phases above high threshold
// - overcurrent means any phase above threshold
// - 97 percent reset hysteresis on thresholds
`ifndef CLP_CFG_SVH
`define CLP_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLP_CLK_MHZ 250
`define CLP_TICK_MS 5
`define CLP_BLOCK_LEAD_MS 5
`define CLP_LOW_DWELL_TIME_MS 10000
`define CLP_HIGH_CURRENT_LIMIT_TIME_MS 30000
`define CLP_MINIMUM_HOLD_TIME_MS 40
`define CLP_HYST_PCT 97

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CLP_REG_CTRL 8'h00
`define CLP_REG_LOW_CURRENT_THRESHOLD 8'h04
`define CLP_REG_HIGH_CURRENT_THRESHOLD 8'h08
`define CLP_REG_OVERCURRENT_RELEASE_THRESHOLD 8'h0c
`define CLP_REG_LOW_DWELL_TIME 8'h10
`define CLP_REG_HIGH_CURRENT_LIMIT_TIME 8'h14
`define CLP_REG_MINIMUM_HOLD_TIME 8'h18
`define CLP_REG_STAT 8'h1c
`define CLP_REG_CNTACT 8'h20
`define CLP_REG_CNTBLK 8'h24
`define CLP_REG_LOGSEL 8'h28
`define CLP_REG_LOGDAT 8'h2c
`define CLP_REG_STAMP 8'h30

// ----------------------------------------------------------------
// control fields and reset values (currents in 0.01 x nominal)
// ----------------------------------------------------------------
`define CLP_CTRL_EN 0
`define CLP_CTRL_TEST 1
`define CLP_CTRL_LNVIS 2
`define CLP_CTRL_EVON 4
`define CLP_CTRL_EVOFF 5
`define CLP_CTRL_CLR 8
`define CLP_CTRL_RST 6'h31
`define CLP_LOW_CURRENT_THRESHOLD_RST 16'h0014
`define CLP_HIGH_CURRENT_THRESHOLD_RST 16'h0078
`define CLP_OVERCURRENT_RELEASE_THRESHOLD_RST 16'h00c8
`define CLP_LOG_DEPTH 12

`endif

/* logic/clp_detector.sv */
// cold load pick-up detector with its register slave
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`include "clp_cfg.svh"
module clp_detector #(
    parameter int TICK_CYCLES = `CLP_TICK_MS * 1000 * `CLP_CLK_MHZ
) (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic sys_rst, // synchronous reset, high
    input wire clp_pkg::clp_ahb_req_s ahbReq, // bus request side
    output clp_pkg::clp_ahb_rsp_s ahbRsp, // bus answer side
    input wire clp_pkg::clp_cur_s phaseCur, // phase magnitudes
    input wire logic [2:0] settingGroup, // active group, for log
    input wire logic coldLoadBlock, // block from blocking matrix
    output logic pickupActive, // pick-up active level
    output logic blocked, // pick-up blocked level
    output clp_pkg::clp_cond_e condStatus, // condition status
    output clp_pkg::clp_ln_e lnBehave, // logical node behaviour
    output clp_pkg::clp_evt_s evt // event pulse and code
);
    import clp_pkg::*;

    localparam clp_tmr_t LOW_DWELL_TIME_RST = clp_tmr_t'(`CLP_LOW_DWELL_TIME_MS / `CLP_TICK_MS);
    localparam clp_tmr_t HIGH_CURRENT_LIMIT_TIME_RST = clp_tmr_t'(`CLP_HIGH_CURRENT_LIMIT_TIME_MS / `CLP_TICK_MS);
    localparam clp_tmr_t MINIMUM_HOLD_TIME_RST = clp_tmr_t'(`CLP_MINIMUM_HOLD_TIME_MS / `CLP_TICK_MS);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    clp_state_s q;
    clp_state_s n;
    clp_rec_s logMem [`CLP_LOG_DEPTH];
    clp_rec_s rec;
    logic logWe;
    logic lowNow;
    logic highNow;
    logic overNow;
    logic blk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic clp_cur_t hyst(input clp_cur_t thr);
        return clp_cur_t'((32'(thr) * `CLP_HYST_PCT) / 100);
    endfunction

    // set above threshold, cleared only below the hysteresis point
    function automatic logic excd(input logic prev, input clp_cur_t i,
                                  input clp_cur_t thr);
        return prev ? (i > hyst(thr)) : (i > thr);
    endfunction

    function automatic clp_tmr_t inc(input clp_tmr_t t);
        return (t == '1) ? t : t + clp_tmr_t'(1);
    endfunction

    function automatic logic expired(input clp_tmr_t t, input clp_tmr_t s);
        return t >= s;
    endfunction

    function automatic logic [2:0] cmp3(input logic [2:0] prev,
                                        input clp_cur_t thr);
        return {excd(prev[2], phaseCur.l3, thr),
                excd(prev[1], phaseCur.l2, thr),
                excd(prev[0], phaseCur.l1, thr)};
    endfunction

    function automatic logic [31:0] rd16(input clp_tmr_t t);
        return {13'h0000, t};
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] nLow;
        logic [2:0] nHigh;
        logic [2:0] nOver;
        logic elem;
        logic rel;
        logic minE;
        logic maxE;
        logic [5:0] now;
        logic [11:0] setMask;
        logic [11:0] clrMask;
        logic cntClr;
        clp_rec_s r;
        nLow = q.exLow;
        nHigh = q.exHigh;
        nOver = q.exOver;
        elem = 1'b0;
        rel = 1'b0;
        minE = 1'b0;
        maxE = 1'b0;
        now = q.lv;
        setMask = 12'h000;
        clrMask = 12'h000;
        cntClr = 1'b0;
        r = '0;
        n = q;
        n.tick = 1'b0;
        n.evt = '0;
        logWe = 1'b0;

        // program-cycle tick from the fast clock
        if (q.div >= TICK_LAST) begin
            n.div = 32'h0000_0000;
            n.tick = 1'b1;
        end else begin
            n.div = q.div + 32'h0000_0001;
        end
        n.blkSync = {q.blkSync[0], coldLoadBlock};
        // block is read only at the tick, one value per cycle
        blk = q.blkSync[1] & q.ctrl[`CLP_CTRL_EN];

        if (q.tick) begin
            n.stamp = q.stamp + 32'h0000_0001;
            nLow = cmp3(q.exLow, q.low_current_threshold);
            nHigh = cmp3(q.exHigh, q.high_current_threshold);
            nOver = cmp3(q.exOver, q.overcurrent_release_threshold);
        end
        lowNow = (nLow == 3'h0);
        highNow = (nHigh == 3'h7);
        overNow = (nOver != 3'h0);

        if (q.tick) begin
            n.exLow = nLow;
            n.exHigh = nHigh;
            n.exOver = nOver;
            unique case (q.st)
                ST_IDLE: begin
                    if (lowNow) begin
                        if (q.low_dwell_time == '0) begin
                            elem = 1'b1;
                        end else begin
                            n.lowTmr = clp_tmr_t'(1);
                            elem = expired(n.lowTmr, q.low_dwell_time);
                            n.st = ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!lowNow) begin
                        n.st = ST_IDLE;
                        n.lowTmr = '0;
                    end else begin
                        n.lowTmr = inc(q.lowTmr);
                        elem = expired(n.lowTmr, q.low_dwell_time);
                    end
                end
                ST_ACT: begin
                    n.minTmr = inc(q.minTmr);
                    minE = expired(n.minTmr, q.minimum_hold_time);
                    if (highNow) begin
                        n.maxTmr = inc(q.maxTmr);
                        maxE = expired(n.maxTmr, q.high_current_limit_time);
                    end
                    // still low: feeder not yet loaded, keep holding
                    rel = blk
                        | overNow
                        | (highNow & maxE)
                        | (!highNow & !lowNow & minE);
                    if (rel) begin
                        n.st = ST_IDLE;
                        n.pickup = 1'b0;
                    end
                end
                ST_BLK: begin
                    if (!blk || !lowNow) begin
                        n.st = ST_IDLE;
                        n.blocked = 1'b0;
                    end
                end
            endcase
            if (elem) begin
                if (blk) begin
                    n.st = ST_BLK;
                    n.blocked = 1'b1;
                end else begin
                    n.st = ST_ACT;
                    n.pickup = 1'b1;
                end
            end
            if (n.st != ST_ACT) begin
                n.minTmr = '0;
                n.maxTmr = '0;
            end
            if (n.st != ST_WAIT) begin
                n.lowTmr = '0;
            end
            if (!q.ctrl[`CLP_CTRL_EN]) begin
                n.st = ST_IDLE;
                n.pickup = 1'b0;
                n.blocked = 1'b0;
                n.lowTmr = '0;
                n.minTmr = '0;
                n.maxTmr = '0;
            end
            now = {n.blocked, n.pickup, overNow,
                   !lowNow & !highNow & !overNow, highNow, lowNow};
            n.lv = now;
            for (int k = 0; k < 6; k++) begin
                if (now[k] && !q.lv[k] && q.ctrl[`CLP_CTRL_EVON]) begin
                    setMask[2 * k] = 1'b1;
                end
                if (!now[k] && q.lv[k] && q.ctrl[`CLP_CTRL_EVOFF]) begin
                    setMask[2 * k + 1] = 1'b1;
                end
            end
        end

        // one event leaves per clock, lowest code first
        for (int k = 11; k >= 0; k--) begin
            if (q.pend[k]) begin
                n.evt.valid = 1'b1;
                n.evt.code = 4'(k);
            end
        end
        if (n.evt.valid) begin
            clrMask[n.evt.code] = 1'b1;
            // only ON events are recorded in the log
            logWe = !n.evt.code[0];
        end
        n.pend = (q.pend & ~clrMask) | setMask;
        r.code = n.evt.code;
        r.group = settingGroup;
        r.stamp = q.stamp;
        r.cur = phaseCur;
        r.toAct = (q.low_dwell_time > q.lowTmr) ? q.low_dwell_time - q.lowTmr : '0;
        r.actTime = q.minTmr;
        r.startTime = q.maxTmr;
        r.reclaim = (q.minimum_hold_time > q.minTmr) ? q.minimum_hold_time - q.minTmr : '0;
        rec = r;
        if (logWe) begin
            n.logWr = (q.logWr == 4'(`CLP_LOG_DEPTH - 1)) ? 4'h0
                                                         : q.logWr + 4'h1;
        end

        // bus data phase writes
        if (q.dWr) begin
            unique case (q.dAddr)
                `CLP_REG_CTRL: begin
                    n.ctrl = ahbReq.hwdata[5:0];
                    cntClr = ahbReq.hwdata[`CLP_CTRL_CLR];
                end
                `CLP_REG_LOW_CURRENT_THRESHOLD: n.low_current_threshold = ahbReq.hwdata[15:0];
                `CLP_REG_HIGH_CURRENT_THRESHOLD: n.high_current_threshold = ahbReq.hwdata[15:0];
                `CLP_REG_OVERCURRENT_RELEASE_THRESHOLD: n.overcurrent_release_threshold = ahbReq.hwdata[15:0];
                `CLP_REG_LOW_DWELL_TIME: n.low_dwell_time = ahbReq.hwdata[18:0];
                `CLP_REG_HIGH_CURRENT_LIMIT_TIME: n.high_current_limit_time = ahbReq.hwdata[18:0];
                `CLP_REG_MINIMUM_HOLD_TIME: n.minimum_hold_time = ahbReq.hwdata[18:0];
                `CLP_REG_LOGSEL: n.logSel = ahbReq.hwdata[6:0];
                default: ;
            endcase
        end
        // a count in the same cycle as a clear survives as one
        if (cntClr) begin
            n.cntAct = 32'h0000_0000;
            n.cntBlk = 32'h0000_0000;
        end
        if (n.pickup && !q.pickup) begin
            n.cntAct = n.cntAct + 32'h0000_0001;
        end
        if (n.blocked && !q.blocked) begin
            n.cntBlk = n.cntBlk + 32'h0000_0001;
        end

        // bus address phase: read data is latched here
        n.dWr = 1'b0;
        if (ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready) begin
            n.dWr = ahbReq.hwrite;
            n.dAddr = ahbReq.haddr[7:0];
            if (!ahbReq.hwrite) begin
                n.rdata = 32'h0000_0000;
                unique case (ahbReq.haddr[7:0])
                    `CLP_REG_CTRL: n.rdata = {26'h0000000, q.ctrl};
                    `CLP_REG_LOW_CURRENT_THRESHOLD: n.rdata = {16'h0000, q.low_current_threshold};
                    `CLP_REG_HIGH_CURRENT_THRESHOLD: n.rdata = {16'h0000, q.high_current_threshold};
                    `CLP_REG_OVERCURRENT_RELEASE_THRESHOLD: n.rdata = {16'h0000, q.overcurrent_release_threshold};
                    `CLP_REG_LOW_DWELL_TIME: n.rdata = rd16(q.low_dwell_time);
                    `CLP_REG_HIGH_CURRENT_LIMIT_TIME: n.rdata = rd16(q.high_current_limit_time);
                    `CLP_REG_MINIMUM_HOLD_TIME: n.rdata = rd16(q.minimum_hold_time);
                    `CLP_REG_STAT: n.rdata = {12'h000, q.st, 6'h00,
                        q.ctrl[`CLP_CTRL_LNVIS], lnBehave, condStatus,
                        q.blkSync[1], q.blocked, q.pickup};
                    `CLP_REG_CNTACT: n.rdata = q.cntAct;
                    `CLP_REG_CNTBLK: n.rdata = q.cntBlk;
                    `CLP_REG_LOGSEL: n.rdata = {21'h000000, q.logWr,
                                                q.logSel};
                    `CLP_REG_LOGDAT: n.rdata = logWord(q.logSel);
                    `CLP_REG_STAMP: n.rdata = q.stamp;
                    default: n.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    function automatic logic [31:0] logWord(input logic [6:0] sel);
        clp_rec_s e;
        e = logMem[(sel[3:0] < 4'(`CLP_LOG_DEPTH)) ? sel[3:0] : 4'h0];
        if (sel[3:0] >= 4'(`CLP_LOG_DEPTH)) begin
            return 32'h0000_0000;
        end
        unique case (sel[6:4])
            3'h0: return {25'h0000000, e.group, e.code};
            3'h1: return e.stamp;
            3'h2: return {e.cur.l2, e.cur.l1};
            3'h3: return {16'h0000, e.cur.l3};
            3'h4: return rd16(e.toAct);
            3'h5: return rd16(e.actTime);
            3'h6: return rd16(e.startTime);
            default: return rd16(e.reclaim);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // state register and log memory
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.ctrl <= `CLP_CTRL_RST;
            q.low_current_threshold <= `CLP_LOW_CURRENT_THRESHOLD_RST;
            q.high_current_threshold <= `CLP_HIGH_CURRENT_THRESHOLD_RST;
            q.overcurrent_release_threshold <= `CLP_OVERCURRENT_RELEASE_THRESHOLD_RST;
            q.low_dwell_time <= LOW_DWELL_TIME_RST;
            q.high_current_limit_time <= HIGH_CURRENT_LIMIT_TIME_RST;
            q.minimum_hold_time <= MINIMUM_HOLD_TIME_RST;
        end else begin
            q <= n;
        end
    end

    // records have no reset: the write pointer marks valid entries
    always_ff @(posedge ref_clk) begin
        if (logWe) begin
            logMem[q.logWr] <= rec;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        if (q.st == ST_BLK) begin
            condStatus = COND_BLOCKED;
        end else if (q.st == ST_ACT) begin
            condStatus = COND_PICKUP;
        end else if (q.exOver != 3'h0) begin
            condStatus = COND_OVER;
        end else if (q.exLow == 3'h0) begin
            condStatus = COND_LOW;
        end else begin
            condStatus = COND_NORMAL;
        end
        if (!q.ctrl[`CLP_CTRL_LNVIS]) begin
            lnBehave = LN_ON;
        end else if (!q.ctrl[`CLP_CTRL_EN]) begin
            lnBehave = LN_OFF;
        end else if (q.ctrl[`CLP_CTRL_TEST]) begin
            lnBehave = q.blkSync[1] ? LN_TEST_BLOCKED : LN_TEST;
        end else begin
            lnBehave = q.blkSync[1] ? LN_BLOCKED : LN_ON;
        end
    end

    assign pickupActive = q.pickup;
    assign blocked = q.blocked;
    assign evt = q.evt;
    assign ahbRsp.hreadyout = 1'b1;
    assign ahbRsp.hresp = 1'b0;
    assign ahbRsp.hrdata = q.rdata;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    pickup_block_excl_a: assert property (
        !(q.pickup && q.blocked))
        else $error("pick-up and blocked both high");
    block_sampled_a: assert property (
        $rose(q.blocked) |-> $past(q.tick) && $past(q.blkSync[1]))
        else $error("blocked rose without sampled block at a tick");
    block_release_a: assert property (
        q.tick && q.st == ST_ACT && q.blkSync[1] |=> !q.pickup)
        else $error("block did not release pick-up");
    over_release_a: assert property (
        q.exOver != 3'h0 |-> !q.pickup)
        else $error("pick-up held during overcurrent");
    dwell_done_a: assert property (
        $rose(q.pickup) |->
        (20'($past(q.lowTmr)) + 20'h1 >= 20'(q.low_dwell_time)))
        else $error("pick-up before dwell time");
    zero_dwell_a: assert property (
        q.tick && q.st == ST_IDLE && q.low_dwell_time == '0 && lowNow
        && !q.blkSync[1] && q.ctrl[`CLP_CTRL_EN] |=> q.pickup)
        else $error("zero dwell did not pick up at once");
    max_release_a: assert property (
        q.tick && q.st == ST_ACT && highNow
        && 20'(q.maxTmr) + 20'h1 >= 20'(q.high_current_limit_time) |=> !q.pickup)
        else $error("high timer expiry did not release");
    min_hold_a: assert property (
        $fell(q.pickup) && q.exOver == 3'h0 && q.exHigh != 3'h7
        && !$past(q.blkSync[1]) && q.ctrl[`CLP_CTRL_EN] |->
        (20'($past(q.minTmr)) + 20'h1 >= 20'(q.minimum_hold_time)))
        else $error("released before minimum hold");
    timers_clear_a: assert property (
        q.st != ST_ACT |-> q.minTmr == '0 && q.maxTmr == '0)
        else $error("timer left running outside pick-up");
endmodule

/* logic/clp_pkg.sv */
// types of the cold load pick-up detector
package clp_pkg;
    typedef logic [18:0] clp_tmr_t;
    typedef logic [15:0] clp_cur_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_ACT = 4'b0100,
        ST_BLK = 4'b1000
    } clp_state_e;

    typedef enum logic [2:0] {
        COND_NORMAL = 3'h0,
        COND_LOW = 3'h1,
        COND_OVER = 3'h2,
        COND_PICKUP = 3'h3,
        COND_BLOCKED = 3'h4
    } clp_cond_e;

    typedef enum logic [2:0] {
        LN_ON = 3'h0,
        LN_BLOCKED = 3'h1,
        LN_TEST = 3'h2,
        LN_TEST_BLOCKED = 3'h3,
        LN_OFF = 3'h4
    } clp_ln_e;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } clp_ahb_req_s;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } clp_ahb_rsp_s;

    typedef struct packed {
        clp_cur_t l1;
        clp_cur_t l2;
        clp_cur_t l3;
    } clp_cur_s;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
    } clp_evt_s;

    typedef struct packed {
        logic [3:0] code;
        logic [2:0] group;
        logic [31:0] stamp;
        clp_cur_s cur;
        clp_tmr_t toAct;
        clp_tmr_t actTime;
        clp_tmr_t startTime;
        clp_tmr_t reclaim;
    } clp_rec_s;

    typedef struct packed {
        clp_state_e st;
        logic [1:0] blkSync;
        logic [31:0] div;
        logic tick;
        logic [31:0] stamp;
        logic [2:0] exLow;
        logic [2:0] exHigh;
        logic [2:0] exOver;
        clp_tmr_t lowTmr;
        clp_tmr_t minTmr;
        clp_tmr_t maxTmr;
        logic pickup;
        logic blocked;
        logic [5:0] lv;
        logic [11:0] pend;
        clp_evt_s evt;
        logic [31:0] cntAct;
        logic [31:0] cntBlk;
        logic [5:0] ctrl;
        clp_cur_t low_current_threshold;
        clp_cur_t high_current_threshold;
        clp_cur_t overcurrent_release_threshold;
        clp_tmr_t low_dwell_time;
        clp_tmr_t high_current_limit_time;
        clp_tmr_t minimum_hold_time;
        logic [6:0] logSel;
        logic [3:0] logWr;
        logic dWr;
        logic [7:0] dAddr;
        logic [31:0] rdata;
    } clp_state_s;
endpackage

/* sim/clp_feed.sv */
// phase current front end and blocking source model for the bench
`timescale 1ns/10ps
module clp_feed (
    input wire logic ref_clk, // bench clock
    input wire logic [1:0] level, // 0 low, 1 normal, 2 high, 3 over
    input wire logic blockReq, // block wanted by the bench
    output clp_pkg::clp_cur_s phaseCur, // three phase magnitudes
    output logic coldLoadBlock // block level to the detector
);
    import clp_pkg::*;
    clp_cur_t mag;
    always_comb begin
        case (level)
            2'h0: mag = 16'h000a;
            2'h1: mag = 16'h003c;
            2'h2: mag = 16'h0096;
            default: mag = 16'h00fa;
        endcase
    end
    // block moves one clock after the request, well ahead of a tick
    always_ff @(posedge ref_clk) begin
        phaseCur <= '{mag, mag, mag};
        coldLoadBlock <= blockReq;
    end
endmodule

/* sim/cold_load_pickup_detector_tb_top.sv */
// self-checking bench of the cold load pick-up detector
`timescale 1ns/10ps
`include "clp_cfg.svh"
module cold_load_pickup_detector_tb_top;
    import clp_pkg::*;
    localparam int TK = 8;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    clp_ahb_req_s busReq = '0;
    clp_ahb_req_s ahbReq;
    clp_ahb_rsp_s ahbRsp;
    clp_cur_s phaseCur;
    logic coldLoadBlock, pickupActive, blocked;
    logic blockReq = 1'b0;
    logic sawAct = 1'b0;
    logic [1:0] level = 2'h1;
    clp_cond_e condStatus;
    clp_ln_e lnBehave;
    clp_evt_s evt;
    logic [31:0] rd;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    always_comb begin
        ahbReq = busReq;
        ahbReq.hready = ahbRsp.hreadyout;
    end
    clp_feed feed (.ref_clk(ref_clk), .level(level), .blockReq(blockReq),
        .phaseCur(phaseCur), .coldLoadBlock(coldLoadBlock));
    clp_detector #(.TICK_CYCLES(TK)) dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .ahbReq(ahbReq), .ahbRsp(ahbRsp),
        .phaseCur(phaseCur), .settingGroup(3'h2),
        .coldLoadBlock(coldLoadBlock), .pickupActive(pickupActive),
        .blocked(blocked), .condStatus(condStatus), .lnBehave(lnBehave),
        .evt(evt));
    always @(posedge ref_clk) begin
        if (evt.valid === 1'b1 && evt.code === 4'h8) sawAct <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        busReq <= '{1'b1, {24'h0, a}, 2'h2, wr, 3'h2, 1'b1, 32'h0};
        do @(posedge ref_clk); while (ahbRsp.hreadyout !== 1'b1);
        busReq <= '{1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 1'b1, d};
        do @(posedge ref_clk); while (ahbRsp.hreadyout !== 1'b1);
        rd = ahbRsp.hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(ahbRsp.hresp), 32'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge ref_clk);
    endtask
    // low current until pick-up, waiting at most n ticks
    task automatic pick(input int n);
        level <= 2'h0;
        for (int i = 0; i < n * TK && pickupActive !== 1'b1; i++)
            @(posedge ref_clk);
        chk(32'(pickupActive), 32'h1);
    endtask
    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rdchk(`CLP_REG_CTRL, 32'h31);
        rdchk(`CLP_REG_LOW_CURRENT_THRESHOLD, 32'h14);
        rdchk(`CLP_REG_HIGH_CURRENT_THRESHOLD, 32'h78);
        rdchk(`CLP_REG_OVERCURRENT_RELEASE_THRESHOLD, 32'hc8);
        rdchk(`CLP_REG_LOW_DWELL_TIME, 32'h7d0);
        rdchk(`CLP_REG_HIGH_CURRENT_LIMIT_TIME, 32'h1770);
        rdchk(`CLP_REG_MINIMUM_HOLD_TIME, 32'h8);
        rdchk(8'h40, 32'h0);
        // first tick logs load normal ON, group 2, in record 0
        rdchk(`CLP_REG_LOGDAT, 32'h24);
        rdchk(`CLP_REG_LOGSEL, 32'h80);
        bus(1'b1, `CLP_REG_LOW_DWELL_TIME, 32'h3);
        bus(1'b1, `CLP_REG_HIGH_CURRENT_LIMIT_TIME, 32'h6);
        bus(1'b1, `CLP_REG_MINIMUM_HOLD_TIME, 32'h4);
        level <= 2'h0;
        ticks(2);
        chk(32'(pickupActive), 32'h0);
        level <= 2'h1;
        ticks(4);
        chk(32'(pickupActive), 32'h0);
        pick(5);
        chk(32'(condStatus), 32'(COND_PICKUP));
        level <= 2'h1;
        ticks(1);
        chk(32'(pickupActive), 32'h1);
        ticks(6);
        chk(32'(pickupActive), 32'h0);
        chk(32'(condStatus), 32'(COND_NORMAL));
        pick(5);
        level <= 2'h3;
        ticks(2);
        chk(32'(pickupActive), 32'h0);
        pick(5);
        level <= 2'h2;
        ticks(4);
        chk(32'(pickupActive), 32'h1);
        ticks(5);
        chk(32'(pickupActive), 32'h0);
        level <= 2'h1;
        blockReq <= 1'b1;
        ticks(2);
        level <= 2'h0;
        ticks(5);
        chk(32'(blocked), 32'h1);
        chk(32'(pickupActive), 32'h0);
        chk(32'(condStatus), 32'(COND_BLOCKED));
        chk(32'(lnBehave), 32'(LN_ON));
        bus(1'b1, `CLP_REG_CTRL, 32'h35);
        @(posedge ref_clk);
        chk(32'(lnBehave), 32'(LN_BLOCKED));
        blockReq <= 1'b0;
        level <= 2'h1;
        ticks(2);
        rdchk(`CLP_REG_CNTBLK, 32'h1);
        pick(5);
        blockReq <= 1'b1;
        ticks(2);
        chk(32'(pickupActive), 32'h0);
        blockReq <= 1'b0;
        level <= 2'h1;
        ticks(2);
        bus(1'b1, `CLP_REG_LOW_DWELL_TIME, 32'h0);
        pick(2);
        level <= 2'h1;
        ticks(8);
        rdchk(`CLP_REG_CNTACT, 32'h5);
        chk(32'(sawAct), 32'h1);
        bus(1'b1, `CLP_REG_CTRL, 32'h131);
        rdchk(`CLP_REG_CNTACT, 32'h0);
        end_of_test();
    end
endmodule
